/* File: hdl/laser_dac_pkg.sv */
// shared constants, register map and types for the laser converter control block
package laser_dac_pkg;
    // register byte offsets on the AHB-Lite slave
    localparam logic [7:0] CFG_OFS = 8'h00;
    localparam logic [7:0] ATTEN_OFS = 8'h04;
    localparam logic [7:0] SETPOINT0_OFS = 8'h08;
    localparam logic [7:0] SETPOINT1_OFS = 8'h0c;
    localparam logic [7:0] BIAS_DIRECT_OFS = 8'h10;
    localparam logic [7:0] MOD_DIRECT_OFS = 8'h14;
    localparam logic [7:0] MOD_SETPOINT_OFS = 8'h18;
    localparam logic [7:0] BIAS_READBACK_OFS = 8'h1c;
    localparam logic [7:0] MOD_READBACK_OFS = 8'h20;
    localparam logic [7:0] STATUS_OFS = 8'h24;

    // configuration register fields
    localparam int CFG_OE = 0;
    localparam int CFG_BYPASS = 1;
    localparam int CFG_BIAS_POL = 2;
    localparam int CFG_FB_INV = 3;
    localparam int CFG_FB_OPT = 4;
    localparam int CFG_SHUTDOWN_POLARITY = 5;
    localparam int CFG_MOD_REF = 6;
    localparam int CFG_RESP = 7;
    localparam int CFG_RES_LO = 8;
    localparam int CFG_EXT_PAR = 11;
    localparam int CFG_SET_SEL = 12;
    localparam int CFG_W = 13;
    // drive off, loop bypassed, internal resistor 1
    localparam logic [CFG_W-1:0] CFG_RESET = 13'h0102;

    // status register fields
    localparam int ST_INIT_DONE = 0;
    localparam int ST_DATA_READY = 1;
    localparam int ST_LASER_ON = 2;
    localparam int ST_FAULT = 3;
    localparam int ST_TXDIS = 4;

    localparam int DAC_W = 8;
    localparam int ATTEN_W = 5;
    localparam logic [DAC_W-1:0] DAC_RESET = 8'h00;
    localparam logic [ATTEN_W-1:0] ATTEN_RESET = 5'h00;

    // timing
    localparam int unsigned CLOCK_HZ = 200_000_000;
    localparam int unsigned INIT_TIME_MS = 50;
    localparam int unsigned LASER_START_DELAY_MS = 300;
    localparam int unsigned CONVERSION_PERIOD_MS = 100;
    localparam int unsigned INIT_CYCLES = INIT_TIME_MS * (CLOCK_HZ / 1000);
    localparam int unsigned LASER_START_CYCLES = LASER_START_DELAY_MS * (CLOCK_HZ / 1000);
    localparam int unsigned CONV_CYCLES = CONVERSION_PERIOD_MS * (CLOCK_HZ / 1000);

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef enum logic [2:0] {
        ST_INIT = 3'b001,
        ST_WAIT = 3'b010,
        ST_RUN = 3'b100
    } power_state_t;

    // one analog drive pin: enable, forced to shutdown level, level when forced
    typedef struct packed {
        logic oe;
        logic shut;
        logic high;
    } drive_t;

    typedef struct packed {
        logic ampInvert;
        logic fbInvert;
        logic fbOptical;
        logic [2:0] fbResSel;
        logic fbExtParallel;
        logic attenBypass;
        logic [ATTEN_W-1:0] attenTap;
    } analog_cfg_t;
endpackage

/* File: hdl/pin_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int W = 2
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [W-1:0] pinIn,
    output logic [W-1:0] pinOut
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] out_reg;

    // first stage feeds only the second; later stages must agree
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            out_reg <= '0;
        end
        else
        begin
            s1_reg <= pinIn;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            out_reg <= (s2_reg & s3_reg) | (out_reg & (s2_reg | s3_reg));
        end
    end

    assign pinOut = out_reg;
endmodule
`default_nettype wire

/* File: hdl/laser_dac_control.sv */
// laser bias and modulation converter control with AHB-Lite register slave
// How it works
// [R01] five-bit attenuator, 1:1 down to 1/32
// [R02] setting zero bypasses and disconnects the divider
// [R03] config bit sets bias amplifier output polarity
// [R04] config bit sets bias feedback polarity
// [R05] feedback reference: current or photodiode
// [R06] pick one of seven resistors, optional parallel
// [R07] loop bypass bit, loop off at reset
// [R08] loop on: bias is setpoint plus table
// [R09] loop off: direct bias register, table ignored
// [R10] applied bias code readable in readback register
// [R11] response bit sets bias code direction
// [R12] swing reference sets modulation direction
// [R13] loop on: modulation is setpoint plus table
// [R14] loop off: direct modulation register used
// [R15] init period, then conversions and bus access
// [R16] drive enable cleared: outputs float
// [R17] shutdown pin level follows its polarity bit
// [R18] bias shutdown level follows bias polarity
// [R19] modulation shutdown level follows swing reference
// [R20] laser off until start delay, then load
// [R21] drive disabled keeps outputs floating indefinitely
// [R22] transmit disable at start keeps outputs shut
// [R23] fault shuts laser down, asserts transmit fault
// [R24] setpoint plus offset clamps, never wraps
//
// Register access over AHB-Lite and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module laser_dac_control #(
    parameter int unsigned INIT_COUNT = laser_dac_pkg::INIT_CYCLES,
    parameter int unsigned START_COUNT = laser_dac_pkg::LASER_START_CYCLES,
    parameter int unsigned CONV_COUNT = laser_dac_pkg::CONV_CYCLES
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic txDisablePin,
    input wire logic faultPin,
    input wire logic [laser_dac_pkg::DAC_W-1:0] biasTableOffset,
    input wire logic [laser_dac_pkg::DAC_W-1:0] modTableOffset,
    output logic [laser_dac_pkg::DAC_W-1:0] biasCode,
    output logic [laser_dac_pkg::DAC_W-1:0] modCode,
    output laser_dac_pkg::drive_t biasDrive,
    output laser_dac_pkg::drive_t modDrive,
    output laser_dac_pkg::drive_t safetyShutdown,
    output laser_dac_pkg::analog_cfg_t analogCfg,
    output logic convStart,
    output logic txFault
);
    import laser_dac_pkg::*;

    // saturating add of unsigned setpoint and signed table offset
    function automatic logic [DAC_W-1:0] clampAdd(input logic [DAC_W-1:0] sp,
                                                  input logic [DAC_W-1:0] off);
        logic signed [DAC_W+1:0] sum;
        sum = $signed({2'b00, sp}) + $signed({{2{off[DAC_W-1]}}, off});
        if (sum < 0)
            return '0;
        if (sum > $signed({2'b00, {DAC_W{1'b1}}}))
            return {DAC_W{1'b1}};
        return sum[DAC_W-1:0];
    endfunction

    // converter code direction: inverted codes make larger numbers drive down
    function automatic logic [DAC_W-1:0] applyDir(input logic [DAC_W-1:0] code,
                                                  input logic invert);
        return invert ? ~code : code;
    endfunction

    power_state_t state_reg;
    power_state_t state_next;
    logic [CFG_W-1:0] cfg_reg;
    logic [ATTEN_W-1:0] atten_reg;
    logic [DAC_W-1:0] setpoint0_reg;
    logic [DAC_W-1:0] setpoint1_reg;
    logic [DAC_W-1:0] biasDirect_reg;
    logic [DAC_W-1:0] modDirect_reg;
    logic [DAC_W-1:0] mod_setpoint_reg;
    logic [DAC_W-1:0] biasLoaded_reg;
    logic [DAC_W-1:0] modLoaded_reg;
    logic [31:0] powerCnt_reg;
    logic [31:0] convCnt_reg;
    logic dataReady_reg;
    logic faultLatch_reg;
    logic wrPend_reg;
    logic [7:0] wrAddr_reg;
    logic [31:0] hrdata_reg;
    logic hreadyout_reg;
    logic [DAC_W-1:0] biasCode_reg;
    logic [DAC_W-1:0] modCode_reg;
    drive_t biasDrive_reg;
    drive_t modDrive_reg;
    drive_t safety_reg;
    analog_cfg_t analog_reg;
    logic convStart_reg;
    logic txFault_reg;

    wire [1:0] pinSync;
    pin_sync #(.W(2)) u_pin_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .pinIn({faultPin, txDisablePin}),
        .pinOut(pinSync)
    );
    wire txDisSync = pinSync[0];
    wire faultSync = pinSync[1];

    // power-up sequencing
    wire initDone = powerCnt_reg >= INIT_COUNT;
    wire startDone = powerCnt_reg >= START_COUNT;
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_INIT: if (initDone) state_next = ST_WAIT; // [R15]
            ST_WAIT: if (startDone) state_next = ST_RUN; // [R20]
            ST_RUN: state_next = ST_RUN;
            default: state_next = ST_INIT;
        endcase
    end

    // bus decode
    wire addrPhase = hsel && hready && (htrans == HTRANS_NONSEQ);
    wire busOpen = state_reg != ST_INIT; // [R15]
    wire writeNow = wrPend_reg && busOpen;
    wire [7:0] rdAddr = haddr[7:0];

    // loop paths
    wire oeBit = cfg_reg[CFG_OE];
    wire bypass = cfg_reg[CFG_BYPASS];
    wire [DAC_W-1:0] selSet = cfg_reg[CFG_SET_SEL] ? setpoint1_reg : setpoint0_reg;
    wire [DAC_W-1:0] biasLoop = clampAdd(selSet, biasTableOffset); // [R08] [R24]
    wire [DAC_W-1:0] modLoop = clampAdd(mod_setpoint_reg, modTableOffset); // [R13] [R24]
    wire [DAC_W-1:0] biasTarget = bypass ? biasDirect_reg : biasLoop; // [R09]
    wire [DAC_W-1:0] modTarget = bypass ? modDirect_reg : modLoop; // [R14]
    // converters stay unloaded while transmit disable holds
    wire loadEnable = (state_reg == ST_RUN) && !txDisSync; // [R20] [R22]
    wire faultActive = faultSync || faultLatch_reg; // [R23]
    wire laserOn = loadEnable && !faultActive && oeBit; // [R21]
    wire [DAC_W-1:0] biasLoadedNext = loadEnable ? biasTarget : biasLoaded_reg;
    wire [DAC_W-1:0] modLoadedNext = loadEnable ? modTarget : modLoaded_reg;
    // fault persists until transmit disable is raised; a new fault wins
    wire faultLatch_next = faultSync || (faultLatch_reg && !txDisSync);
    wire convWrap = convCnt_reg >= (CONV_COUNT - 32'd1);

    wire [31:0] statusWord = {27'h0, txDisSync, faultActive, laserOn, dataReady_reg, initDone};
    wire [31:0] readWord =
        !busOpen ? 32'h0 :
        (rdAddr == CFG_OFS) ? {{(32-CFG_W){1'b0}}, cfg_reg} :
        (rdAddr == ATTEN_OFS) ? {{(32-ATTEN_W){1'b0}}, atten_reg} :
        (rdAddr == SETPOINT0_OFS) ? {24'h0, setpoint0_reg} :
        (rdAddr == SETPOINT1_OFS) ? {24'h0, setpoint1_reg} :
        (rdAddr == BIAS_DIRECT_OFS) ? {24'h0, biasDirect_reg} :
        (rdAddr == MOD_DIRECT_OFS) ? {24'h0, modDirect_reg} :
        (rdAddr == MOD_SETPOINT_OFS) ? {24'h0, mod_setpoint_reg} :
        (rdAddr == BIAS_READBACK_OFS) ? {24'h0, biasLoaded_reg} : // [R10]
        (rdAddr == MOD_READBACK_OFS) ? {24'h0, modLoaded_reg} :
        (rdAddr == STATUS_OFS) ? statusWord : 32'h0;

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_reg <= ST_INIT;
            powerCnt_reg <= 32'h0;
            convCnt_reg <= 32'h0;
            dataReady_reg <= 1'b0;
            convStart_reg <= 1'b0;
            faultLatch_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            if (!startDone)
                powerCnt_reg <= powerCnt_reg + 32'd1;
            convStart_reg <= 1'b0;
            if (busOpen)
            begin
                convCnt_reg <= convWrap ? 32'h0 : convCnt_reg + 32'd1;
                convStart_reg <= convWrap;
                if (convWrap)
                    dataReady_reg <= 1'b1;
            end
            faultLatch_reg <= faultLatch_next;
        end
    end

    // AHB-Lite slave, zero wait states; only word writes are stored
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wrPend_reg <= 1'b0;
            wrAddr_reg <= 8'h0;
            hrdata_reg <= 32'h0;
            hreadyout_reg <= 1'b1;
        end
        else
        begin
            wrPend_reg <= addrPhase && hwrite && (hsize == HSIZE_WORD);
            if (addrPhase)
                wrAddr_reg <= haddr[7:0];
            if (addrPhase && !hwrite)
                hrdata_reg <= readWord;
            hreadyout_reg <= 1'b1;
        end
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cfg_reg <= CFG_RESET; // [R07] [R16]
            atten_reg <= ATTEN_RESET;
            setpoint0_reg <= DAC_RESET;
            setpoint1_reg <= DAC_RESET;
            biasDirect_reg <= DAC_RESET;
            modDirect_reg <= DAC_RESET;
            mod_setpoint_reg <= DAC_RESET;
        end
        else if (writeNow)
        begin
            if (wrAddr_reg == CFG_OFS)
                cfg_reg <= hwdata[CFG_W-1:0];
            if (wrAddr_reg == ATTEN_OFS)
                atten_reg <= hwdata[ATTEN_W-1:0];
            if (wrAddr_reg == SETPOINT0_OFS)
                setpoint0_reg <= hwdata[DAC_W-1:0];
            if (wrAddr_reg == SETPOINT1_OFS)
                setpoint1_reg <= hwdata[DAC_W-1:0];
            if (wrAddr_reg == BIAS_DIRECT_OFS)
                biasDirect_reg <= hwdata[DAC_W-1:0];
            if (wrAddr_reg == MOD_DIRECT_OFS)
                modDirect_reg <= hwdata[DAC_W-1:0];
            if (wrAddr_reg == MOD_SETPOINT_OFS)
                mod_setpoint_reg <= hwdata[DAC_W-1:0];
        end
    end

    // converter codes and pin states
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            biasLoaded_reg <= DAC_RESET;
            modLoaded_reg <= DAC_RESET;
            biasCode_reg <= DAC_RESET;
            modCode_reg <= DAC_RESET;
            biasDrive_reg <= '{oe: 1'b0, shut: 1'b1, high: 1'b0};
            modDrive_reg <= '{oe: 1'b0, shut: 1'b1, high: 1'b0};
            safety_reg <= '{oe: 1'b0, shut: 1'b1, high: 1'b0};
            analog_reg <= '0;
            txFault_reg <= 1'b0;
        end
        else
        begin
            biasLoaded_reg <= biasLoadedNext; // [R10]
            modLoaded_reg <= modLoadedNext;
            biasCode_reg <= applyDir(biasLoadedNext, cfg_reg[CFG_RESP]); // [R11]
            modCode_reg <= applyDir(modLoadedNext, cfg_reg[CFG_MOD_REF]); // [R12]
            biasDrive_reg <= '{oe: oeBit, shut: !laserOn, high: cfg_reg[CFG_BIAS_POL]}; // [R18]
            modDrive_reg <= '{oe: oeBit, shut: !laserOn, high: cfg_reg[CFG_MOD_REF]}; // [R19]
            // shutdown pin is active in its polarity whenever the drive enable bit is set and the laser is off
            safety_reg <= '{oe: oeBit, shut: !laserOn,
                            high: laserOn ? !cfg_reg[CFG_SHUTDOWN_POLARITY] : cfg_reg[CFG_SHUTDOWN_POLARITY]}; // [R17]
            analog_reg.ampInvert <= cfg_reg[CFG_BIAS_POL]; // [R03]
            analog_reg.fbInvert <= cfg_reg[CFG_FB_INV]; // [R04]
            analog_reg.fbOptical <= cfg_reg[CFG_FB_OPT]; // [R05]
            analog_reg.fbResSel <= cfg_reg[CFG_RES_LO +: 3]; // [R06]
            analog_reg.fbExtParallel <= cfg_reg[CFG_EXT_PAR]; // [R06]
            analog_reg.attenBypass <= atten_reg == ATTEN_RESET; // [R02]
            analog_reg.attenTap <= atten_reg; // [R01]
            txFault_reg <= faultActive; // [R23]
        end
    end

    assign hrdata = hrdata_reg;
    assign hreadyout = hreadyout_reg;
    assign hresp = 1'b0;
    assign biasCode = biasCode_reg;
    assign modCode = modCode_reg;
    assign biasDrive = biasDrive_reg;
    assign modDrive = modDrive_reg;
    assign safetyShutdown = safety_reg;
    assign analogCfg = analog_reg;
    assign convStart = convStart_reg;
    assign txFault = txFault_reg;

    a_drive_float: assert property (@(posedge clock) disable iff (sys_rst) // [R21]
        !oeBit |=> !biasDrive.oe && !modDrive.oe && !safetyShutdown.oe)
        else $error("drive enabled while output enable bit clear");

    a_fault_shut: assert property (@(posedge clock) disable iff (sys_rst) // [R23]
        faultSync |=> biasDrive.shut && modDrive.shut && txFault)
        else $error("fault did not shut the laser down");

    a_start_wait: assert property (@(posedge clock) disable iff (sys_rst) // [R20]
        (state_reg != ST_RUN) |=> biasDrive.shut && modDrive.shut)
        else $error("laser on before start delay");

    a_txdis_shut: assert property (@(posedge clock) disable iff (sys_rst) // [R22]
        txDisSync |=> biasDrive.shut && modDrive.shut && (biasLoaded_reg == $past(biasLoaded_reg)))
        else $error("outputs active under transmit disable");

    a_direct_bias: assert property (@(posedge clock) disable iff (sys_rst) // [R09]
        loadEnable && bypass |=> biasLoaded_reg == $past(biasDirect_reg))
        else $error("direct bias not applied with loop off");

    a_mod_loop: assert property (@(posedge clock) disable iff (sys_rst) // [R13]
        loadEnable && !bypass && (modTableOffset == 8'h00) |=> modLoaded_reg == $past(mod_setpoint_reg))
        else $error("modulation setpoint not applied with loop on");

    a_clamp_top: assert property (@(posedge clock) disable iff (sys_rst) // [R24]
        loadEnable && !bypass && (selSet == 8'hff) && !biasTableOffset[DAC_W-1]
        |=> biasLoaded_reg == 8'hff)
        else $error("bias sum wrapped instead of clamping");

    a_atten_bypass: assert property (@(posedge clock) disable iff (sys_rst) // [R02]
        (atten_reg == 5'h00) |=> analogCfg.attenBypass)
        else $error("attenuator not bypassed at setting zero");

    a_shut_level: assert property (@(posedge clock) disable iff (sys_rst) // [R17]
        oeBit && !laserOn |=> safetyShutdown.high == $past(cfg_reg[CFG_SHUTDOWN_POLARITY]))
        else $error("shutdown pin level does not follow its polarity bit");

    a_bus_closed: assert property (@(posedge clock) disable iff (sys_rst) // [R15]
        addrPhase && !hwrite && !busOpen |=> hrdata == 32'h0)
        else $error("register read answered during initialisation");

    a_bias_dir: assert property (@(posedge clock) disable iff (sys_rst) // [R11]
        1'b1 |=> biasCode == ($past(cfg_reg[CFG_RESP]) ? ~biasLoaded_reg : biasLoaded_reg))
        else $error("bias code direction wrong");
endmodule
`default_nettype wire

/* File: dv/laser_driver_model.sv */
// far-side model: laser driver and bias transistor seen through the drive pins
`timescale 1ns/1ps
`default_nettype none
module laser_driver_model (
    input wire logic clock,
    input wire laser_dac_pkg::drive_t biasDrive,
    input wire laser_dac_pkg::drive_t modDrive,
    input wire logic injectFault,
    output logic faultPin,
    output logic laserLit
);
    import laser_dac_pkg::*;
    // external driver reports its fault one cycle after it trips
    always_ff @(posedge clock)
    begin
        faultPin <= injectFault;
    end
    // current flows only while both drive pins are driven and not forced off
    assign laserLit = biasDrive.oe & ~biasDrive.shut & modDrive.oe & ~modDrive.shut;
endmodule
`default_nettype wire

/* File: dv/laser_dac_control_tb_top.sv */
// self-checking bench for the laser converter control block
`timescale 1ns/1ps
`default_nettype none
module laser_dac_control_tb_top;
    import laser_dac_pkg::*;
    localparam int unsigned IC = 20;
    localparam int unsigned SC = 50;
    localparam int unsigned CC = 10;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic txDisablePin = 1'b0;
    logic injectFault = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h0;
    logic [DAC_W-1:0] biasOff = 8'h00;
    logic [DAC_W-1:0] modOff = 8'h00;
    logic [31:0] hrdata;
    logic [31:0] q;
    logic hreadyout, hresp, convStart, txFault, faultPin, laserLit;
    logic [DAC_W-1:0] biasCode, modCode, lb, lm;
    logic [DAC_W-1:0] v [5];
    logic [CFG_W-1:0] cfg;
    logic [12:0] ea;
    logic [ATTEN_W-1:0] at;
    drive_t biasDrive, modDrive, safetyShutdown;
    analog_cfg_t analogCfg;
    int errorCnt = 0;
    int nTests = 0;
    int cyc = 0;
    int convCnt = 0;
    int c0, k;

    laser_dac_control #(.INIT_COUNT(IC), .START_COUNT(SC), .CONV_COUNT(CC)) uut (
        .clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .txDisablePin(txDisablePin), .faultPin(faultPin), .biasTableOffset(biasOff),
        .modTableOffset(modOff), .biasCode(biasCode), .modCode(modCode),
        .biasDrive(biasDrive), .modDrive(modDrive), .safetyShutdown(safetyShutdown),
        .analogCfg(analogCfg), .convStart(convStart), .txFault(txFault));

    laser_driver_model partner (.clock(clock), .biasDrive(biasDrive), .modDrive(modDrive),
        .injectFault(injectFault), .faultPin(faultPin), .laserLit(laserLit));

    initial
    begin
        forever #2.5 clock = ~clock;
    end

    task automatic finishTest;
        if (errorCnt == 0 && nTests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // whole run is under a thousand cycles; this only catches a hang
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (convStart === 1'b1)
            convCnt <= convCnt + 1;
        if (cyc == 3000)
        begin
            errorCnt++;
            finishTest();
        end
    end

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        nTests++;
        if (s !== e)
        begin
            errorCnt++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    // single word transfer; read data lands in q
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        hsize <= HSIZE_WORD;
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        q = hrdata;
    endtask

    function automatic logic [7:0] clampAdd(input logic [7:0] sp, input logic [7:0] off);
        logic signed [9:0] s;
        s = $signed({2'b00, sp}) + $signed({{2{off[7]}}, off});
        return (s < 0) ? 8'h00 : ((s > 255) ? 8'hff : s[7:0]);
    endfunction

    initial
    begin
        void'($urandom(69));
        tick(20);
        sys_rst <= 1'b0;
        bus(1'b0, STATUS_OFS, 32'h0);
        chk("statusInit", q, 32'h0);
        chk("hresp", 32'(hresp), 32'h0);
        tick(IC);
        bus(1'b0, CFG_OFS, 32'h0);
        chk("cfgReset", q, 32'(CFG_RESET));
        chk("analogReset", 32'(analogCfg), 32'h0a0);
        chk("oeReset", 32'({biasDrive.oe, modDrive.oe, safetyShutdown.oe}), 32'h0);
        bus(1'b1, CFG_OFS, 32'h0103);
        tick(10);
        chk("laserEarly", 32'(laserLit), 32'h0);
        tick(SC);
        chk("laserStart", 32'(laserLit), 32'h1);
        c0 = convCnt;
        tick(3 * CC);
        chk("convCount", 32'(convCnt - c0), 32'h3);
        for (int i = 0; i < 10; i++)
        begin
            foreach (v[j]) v[j] = (i < 2) ? (i == 0 ? 8'h05 : 8'hff) : 8'($urandom);
            cfg = 13'($urandom);
            cfg[CFG_OE] = 1'b1;
            if (i < 3)
                cfg[CFG_BYPASS] = 1'b0;
            at = (i == 2) ? 5'h00 : 5'($urandom);
            biasOff <= (i == 0) ? 8'h80 : ((i == 1) ? 8'h7f : 8'($urandom));
            modOff <= (i == 0) ? 8'h80 : ((i == 1) ? 8'h7f : ((i == 2) ? 8'h00 : 8'($urandom)));
            bus(1'b1, SETPOINT0_OFS, 32'(v[0]));
            bus(1'b1, SETPOINT1_OFS, 32'(v[1]));
            bus(1'b1, BIAS_DIRECT_OFS, 32'(v[2]));
            bus(1'b1, MOD_DIRECT_OFS, 32'(v[3]));
            bus(1'b1, MOD_SETPOINT_OFS, 32'(v[4]));
            bus(1'b1, ATTEN_OFS, 32'(at));
            bus(1'b1, CFG_OFS, 32'(cfg));
            tick(3);
            lb = cfg[CFG_BYPASS] ? v[2] : clampAdd(cfg[CFG_SET_SEL] ? v[1] : v[0], biasOff);
            lm = cfg[CFG_BYPASS] ? v[3] : clampAdd(v[4], modOff);
            chk("biasCode", 32'(biasCode), 32'(lb ^ {8{cfg[CFG_RESP]}}));
            chk("modCode", 32'(modCode), 32'(lm ^ {8{cfg[CFG_MOD_REF]}}));
            ea = {cfg[CFG_BIAS_POL], cfg[CFG_FB_INV], cfg[CFG_FB_OPT], cfg[CFG_RES_LO +: 3],
                  cfg[CFG_EXT_PAR], at == 5'h00, at};
            chk("analogCfg", 32'(analogCfg), 32'(ea));
            chk("shdnRun", 32'(safetyShutdown), 32'({2'b10, ~cfg[CFG_SHUTDOWN_POLARITY]}));
            bus(1'b0, BIAS_READBACK_OFS, 32'h0);
            chk("readback", q, 32'(lb));
            bus(1'b0, MOD_READBACK_OFS, 32'h0);
            chk("modReadback", q, 32'(lm));
        end
        bus(1'b0, 8'h3c, 32'h0);
        chk("unmapped", q, 32'h0);
        txDisablePin <= 1'b1;
        tick(6);
        for (int i = 0; i < 16; i++)
        begin
            cfg = 13'($urandom);
            cfg[CFG_OE] = i[0];
            bus(1'b1, CFG_OFS, 32'(cfg));
            tick(3);
            if (cfg[CFG_OE])
            begin
                chk("biasShut", 32'(biasDrive), 32'({2'b11, cfg[CFG_BIAS_POL]}));
                chk("modShut", 32'(modDrive), 32'({2'b11, cfg[CFG_MOD_REF]}));
                chk("shdnShut", 32'(safetyShutdown), 32'({2'b11, cfg[CFG_SHUTDOWN_POLARITY]}));
            end
            else
                chk("oeOff", 32'({biasDrive.oe, modDrive.oe, safetyShutdown.oe}), 32'h0);
        end
        txDisablePin <= 1'b0;
        bus(1'b1, CFG_OFS, 32'h0123);
        tick(6);
        chk("laserBack", 32'(laserLit), 32'h1);
        injectFault <= 1'b1;
        k = 0;
        while (txFault !== 1'b1 && k < 8)
        begin
            tick(1);
            k++;
        end
        chk("txFault", 32'(txFault), 32'h1);
        chk("faultShdn", 32'(safetyShutdown), 32'h7);
        chk("faultLaser", 32'(laserLit), 32'h0);
        injectFault <= 1'b0;
        tick(8);
        chk("faultHeld", 32'(txFault), 32'h1);
        txDisablePin <= 1'b1;
        tick(8);
        txDisablePin <= 1'b0;
        tick(8);
        chk("faultClear", 32'({txFault, laserLit}), 32'h1);
        sys_rst <= 1'b1;
        txDisablePin <= 1'b1;
        tick(20);
        sys_rst <= 1'b0;
        tick(IC + 3);
        bus(1'b1, CFG_OFS, 32'h0103);
        c0 = convCnt;
        tick(SC);
        chk("txDisStart", 32'({biasDrive.shut, modDrive.shut, laserLit}), 32'h6);
        chk("txDisConv", 32'(convCnt > c0), 32'h1);
        bus(1'b0, STATUS_OFS, 32'h0);
        chk("initDone", 32'(q[ST_INIT_DONE]), 32'h1);
        chk("status", q, 32'h13);
        finishTest();
    end
endmodule
`default_nettype wire
